// ===== hdl/ocsa_pkg.sv
// Operation
// RULE1: Each accumulator digit counts modulo two; overflow sets that digit's carry.
// RULE2: Add leaves digit sums and carries stored; no propagation during the add.
// RULE3: Each carry pulse moves every set carry one digit left, clearing it.
// RULE4: Controller allows up to width minus one carry steps for a full ripple; the controller here waits up to twice width cycles for it.
// RULE5: Negation inverts every accumulator bit, no carries, no addition time.
// RULE6: Subtract adds complemented subtrahend; negative results stay complemented.
// RULE7: Carry out of the leftmost digit is added into the rightmost digit.
// RULE8: Multiplicand and multiplier registers hold operands; product builds in accumulator.
// RULE9: Multiply step with multiplier bit zero set adds multiplicand into accumulator.
// RULE10: Multiply step with multiplier bit zero clear shifts accumulator and multiplier right.
// RULE11: Bit leaving accumulator right end enters multiplier leftmost position.
// RULE12: Multiplicand register never shifts or changes during multiplication.
// RULE13: Conditional add then shift repeats until all multiplier digits are examined.
// RULE14: The adding step pulse also clears the multiplier's rightmost bit.
// RULE15: Step counter advances per shift; its overflow ends the multiply run.
// RULE16: Controller issues one carry step after each multiplicand addition.
// RULE17: Controller runs a full carry after the last step before using product.
// RULE18: Word width is one parameter shared by all registers and counter.
// RULE19: One-cycle done pulses when multiply stops and when full carry clears.
package ocsa_pkg;
	localparam int OCSA_WIDTH = 16; // RULE18
	localparam int OCSA_CNT_W = $clog2(OCSA_WIDTH);
	localparam logic [OCSA_WIDTH-1:0] OCSA_WORD_RST = 16'h0000;
	localparam logic [OCSA_CNT_W-1:0] OCSA_CNT_RST = 4'h0;
	localparam logic [OCSA_CNT_W-1:0] OCSA_CNT_LAST = 4'hF;

	typedef logic [OCSA_WIDTH-1:0] ocsa_word_t;

	// One-cycle operation pulses from the sequencer
	typedef struct packed {
		logic load_acc;
		logic clear_acc;
		logic load_mcand;
		logic load_mplier;
		logic add_mcand;
		logic sub_mcand;
		logic negate;
		logic carry_step;
		logic full_carry;
		logic mult_start;
		logic mult_step;
	} ocsa_cmd_t;

	typedef struct packed {
		ocsa_word_t carry;
		ocsa_word_t sum;
	} ocsa_acc_t;

	typedef enum logic [1:0] {
		OCSA_IDLE = 2'h0,
		OCSA_MULT = 2'h1,
		OCSA_FULL = 2'h2
	} ocsa_state_t;

	// Digit-wise add without propagation; a set carry met by a new one is lost,
	// which the sequencer prevents by single carry steps between adds
	function automatic ocsa_acc_t ocsa_add(input ocsa_acc_t acc, input ocsa_word_t x);
		ocsa_acc_t r;
		r.sum = acc.sum ^ x; // RULE1
		r.carry = acc.carry | (acc.sum & x); // RULE2
		return r;
	endfunction
endpackage

// ===== hdl/ocsa_carry_step.sv
`timescale 1ns/10ps
module ocsa_carry_step
	import ocsa_pkg::*;
(
	input ocsa_acc_t acc,
	output ocsa_acc_t stepped
);
	ocsa_word_t incoming;

	// Leftmost carry wraps round into digit zero
	assign incoming = {acc.carry[OCSA_WIDTH-2:0], acc.carry[OCSA_WIDTH-1]}; // RULE3 RULE7
	assign stepped.sum = acc.sum ^ incoming; // RULE3
	assign stepped.carry = acc.sum & incoming; // RULE3
endmodule

// ===== hdl/ocsa_alu.sv
`timescale 1ns/10ps
module ocsa_alu
	import ocsa_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input ocsa_cmd_t CMD,
	input ocsa_word_t DATA_IN,
	output ocsa_word_t ACC_SUM,
	output ocsa_word_t ACC_CARRY,
	output ocsa_word_t MCAND,
	output ocsa_word_t MPLIER,
	output logic MULT_RUN,
	output logic FULL_CARRY_RUN,
	output logic MULT_DONE,
	output logic CARRY_DONE
);
	ocsa_acc_t sum_accumulator;
	ocsa_word_t multiplicand_reg;
	ocsa_word_t multiplier_reg;
	logic [OCSA_CNT_W-1:0] step_count;
	ocsa_state_t state;
	ocsa_state_t next_state;
	ocsa_acc_t stepped;
	ocsa_acc_t next_acc;
	logic idle;
	logic do_add;
	logic do_sub;
	logic do_neg;
	logic do_load;
	logic do_clear;
	logic do_carry;
	logic do_madd;
	logic do_shift;
	logic last_shift;
	logic fc_finish;

	ocsa_carry_step u_carry (
		.acc(sum_accumulator),
		.stepped(stepped)
	);

	// Only carry steps and multiply steps are honoured while multiplying,
	// so operands cannot be disturbed mid-sequence
	assign idle = (state == OCSA_IDLE);
	assign do_load = idle && CMD.load_acc;
	assign do_clear = idle && CMD.clear_acc;
	assign do_add = idle && CMD.add_mcand;
	assign do_sub = idle && CMD.sub_mcand;
	assign do_neg = idle && CMD.negate;
	assign do_carry = (state != OCSA_FULL) && CMD.carry_step;
	assign do_madd = (state == OCSA_MULT) && CMD.mult_step && multiplier_reg[0]; // RULE9
	assign do_shift = (state == OCSA_MULT) && CMD.mult_step && !multiplier_reg[0]; // RULE10
	assign last_shift = do_shift && (step_count == OCSA_CNT_LAST); // RULE15
	assign fc_finish = (state == OCSA_FULL) && (sum_accumulator.carry == OCSA_WORD_RST);

	always_comb begin
		next_acc = sum_accumulator;
		if (state == OCSA_FULL) begin
			next_acc = stepped;
		end else if (do_load) begin
			next_acc.sum = DATA_IN;
			next_acc.carry = OCSA_WORD_RST;
		end else if (do_clear) begin
			next_acc.sum = OCSA_WORD_RST;
			next_acc.carry = OCSA_WORD_RST;
		end else if (do_add || do_madd) begin
			next_acc = ocsa_add(sum_accumulator, multiplicand_reg); // RULE8 RULE9
		end else if (do_sub) begin
			next_acc = ocsa_add(sum_accumulator, ~multiplicand_reg); // RULE6
		end else if (do_neg) begin
			next_acc.sum = ~sum_accumulator.sum; // RULE5
		end else if (do_carry) begin
			next_acc = stepped; // RULE3
		end else if (do_shift) begin
			// Both rows move right; carry bound for old digit one lands in digit zero
			next_acc.sum = {1'b0, sum_accumulator.sum[OCSA_WIDTH-1:1]}; // RULE10
			next_acc.carry = {1'b0, sum_accumulator.carry[OCSA_WIDTH-1:1]};
			next_acc.sum[0] = sum_accumulator.sum[1] ^ sum_accumulator.carry[0];
			next_acc.carry[0] = sum_accumulator.carry[1]
				| (sum_accumulator.sum[1] & sum_accumulator.carry[0]);
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sum_accumulator <= '0;
		end else begin
			sum_accumulator <= next_acc;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			multiplicand_reg <= OCSA_WORD_RST;
		end else if (idle && CMD.load_mcand) begin
			multiplicand_reg <= DATA_IN; // RULE12
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			multiplier_reg <= OCSA_WORD_RST;
		end else if (idle && CMD.load_mplier) begin
			multiplier_reg <= DATA_IN;
		end else if (do_madd) begin
			multiplier_reg[0] <= 1'b0; // RULE14
		end else if (do_shift) begin
			multiplier_reg <= {sum_accumulator.sum[0], multiplier_reg[OCSA_WIDTH-1:1]}; // RULE11
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			step_count <= OCSA_CNT_RST;
		end else if (idle && CMD.mult_start) begin
			step_count <= OCSA_CNT_RST;
		end else if (do_shift) begin
			step_count <= step_count + 1'b1; // RULE15
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			OCSA_IDLE: begin
				if (CMD.mult_start) begin
					next_state = OCSA_MULT;
				end else if (CMD.full_carry) begin
					next_state = OCSA_FULL;
				end
			end
			OCSA_MULT: begin
				if (last_shift) begin
					next_state = OCSA_IDLE; // RULE13 RULE15
				end
			end
			OCSA_FULL: begin
				if (fc_finish) begin
					next_state = OCSA_IDLE;
				end
			end
			default: begin
				next_state = OCSA_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state <= OCSA_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			MULT_DONE <= 1'b0;
			CARRY_DONE <= 1'b0;
		end else begin
			MULT_DONE <= last_shift; // RULE19
			CARRY_DONE <= fc_finish; // RULE19
		end
	end

	assign ACC_SUM = sum_accumulator.sum;
	assign ACC_CARRY = sum_accumulator.carry;
	assign MCAND = multiplicand_reg;
	assign MPLIER = multiplier_reg;
	assign MULT_RUN = (state == OCSA_MULT);
	assign FULL_CARRY_RUN = (state == OCSA_FULL);

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_add_no_ripple: assert property (do_add |=> ACC_SUM == ($past(ACC_SUM) ^ $past(MCAND))
		&& ACC_CARRY == ($past(ACC_CARRY) | ($past(ACC_SUM) & $past(MCAND)))) // RULE2
		else $error("add did not leave digit sums and carries");
	a_carry_one_step: assert property (do_carry |=> ACC_CARRY == ($past(ACC_SUM)
		& {$past(ACC_CARRY[OCSA_WIDTH-2:0]), $past(ACC_CARRY[OCSA_WIDTH-1])})) // RULE3
		else $error("carry step moved carries wrongly");
	a_end_around: assert property (do_carry && ACC_CARRY[OCSA_WIDTH-1]
		|=> ACC_SUM[0] != $past(ACC_SUM[0])) // RULE7
		else $error("top carry not added into digit zero");
	a_negate_invert: assert property (do_neg |=> ACC_SUM == ~$past(ACC_SUM)
		&& $stable(ACC_CARRY)) // RULE5
		else $error("negate did not invert word");
	a_sub_complement: assert property (do_sub
		|=> ACC_SUM == ($past(ACC_SUM) ^ ~$past(MCAND))) // RULE6
		else $error("subtract did not add complement");
	a_madd_clears_bit: assert property (do_madd |=> !MPLIER[0]
		&& ACC_SUM == ($past(ACC_SUM) ^ $past(MCAND))) // RULE9 RULE14
		else $error("multiply add step wrong");
	a_shift_pair: assert property (do_shift |=> MPLIER == {$past(ACC_SUM[0]),
		$past(MPLIER[OCSA_WIDTH-1:1])} && !ACC_SUM[OCSA_WIDTH-1]) // RULE10 RULE11
		else $error("multiply shift wrong");
	a_mcand_hold: assert property (MULT_RUN |=> $stable(MCAND)) // RULE12
		else $error("multiplicand changed during multiply");
	a_mult_stop: assert property (last_shift // RULE15 RULE19
		|=> MULT_DONE && !MULT_RUN ##1 !MULT_DONE)
		else $error("multiply did not stop after last shift");
	a_carry_done: assert property (CARRY_DONE |-> ACC_CARRY == OCSA_WORD_RST
		&& $past(FULL_CARRY_RUN) && !FULL_CARRY_RUN) // RULE19
		else $error("full carry done with carries pending");
	// Each full-carry cycle with carries pending moves every carry one digit left, the top one into digit zero
	a_full_step: assert property (FULL_CARRY_RUN && ACC_CARRY != OCSA_WORD_RST // RULE3 RULE7
		|=> ACC_CARRY == ($past(ACC_SUM)
		& {$past(ACC_CARRY[OCSA_WIDTH-2:0]), $past(ACC_CARRY[OCSA_WIDTH-1])}))
		else $error("full carry step moved carries wrongly");
	a_shift_count: assert property (do_shift && !last_shift // RULE15
		|=> MULT_RUN && step_count == $past(step_count) + OCSA_CNT_W'(1))
		else $error("step counter did not advance on shift");
	a_madd_no_count: assert property (do_madd |=> $stable(step_count) && MULT_RUN) // RULE15
		else $error("add step moved the step counter");
	a_full_done: assert property (fc_finish |=> CARRY_DONE && !FULL_CARRY_RUN) // RULE19
		else $error("full carry did not stop once carries cleared");
	a_full_keeps_low: assert property (FULL_CARRY_RUN |=> $stable(MPLIER) && $stable(MCAND)) // RULE11
		else $error("operand registers changed during full carry");
endmodule

// ===== testbench/ocsa_seq_model.sv
`timescale 1ns/10ps
module ocsa_seq_model
	import ocsa_pkg::*;
(
	input wire logic CLK,
	input ocsa_word_t MPLIER,
	input wire logic MULT_RUN,
	input wire logic MULT_DONE,
	input wire logic CARRY_DONE,
	output ocsa_cmd_t CMD,
	output ocsa_word_t DATA_IN
);
	int timeouts = 0;
	int shifts = 0;
	logic mult_done_seen, carry_seen;
	initial {CMD, DATA_IN} = '0;
	// Word inverted after the load so a late sample is caught
	task automatic issue(input int idx, input ocsa_word_t d);
		@(negedge CLK);
		CMD = '0;
		CMD[idx] = 1'b1;
		DATA_IN = d;
		@(negedge CLK);
		CMD = '0;
		DATA_IN = ~d;
	endtask
	// Bound covers an end-around ripple through every digit
	task automatic full_carry();
		int n;
		n = 0;
		issue(2, '0);
		while (!CARRY_DONE && n < 2 * OCSA_WIDTH) begin
			@(negedge CLK);
			n++;
		end
		carry_seen = CARRY_DONE;
		if (!carry_seen) timeouts++;
	endtask
	task automatic multiply(input ocsa_word_t a, input ocsa_word_t b);
		int n;
		n = 0;
		shifts = 0;
		issue(8, a);
		issue(7, b);
		issue(9, '0);
		issue(1, '0);
		while (MULT_RUN === 1'b1 && n < 4 * OCSA_WIDTH) begin
			n++;
			if (MPLIER[0] === 1'b1) begin
				// Back-to-back shifts can leave digit zero holding three; settle it first
				issue(3, '0);
				issue(0, '0);
				issue(3, '0);
			end else begin
				issue(0, '0);
				shifts++;
			end
		end
		mult_done_seen = MULT_DONE;
		if (n >= 4 * OCSA_WIDTH) timeouts++;
		full_carry();
	endtask
endmodule

// ===== testbench/test_ones_complement_shift_add_alu.sv
`timescale 1ns/10ps
module test_ones_complement_shift_add_alu
	import ocsa_pkg::*;
;
	localparam int M = 32'h0000FFFF;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	ocsa_cmd_t CMD;
	ocsa_word_t DATA_IN, ACC_SUM, ACC_CARRY, MCAND, MPLIER;
	logic MULT_RUN, FULL_CARRY_RUN, MULT_DONE, CARRY_DONE;
	int mismatches = 0;
	int total_checks = 0;
	int a, b, c, r;
	always #5 CLK = ~CLK;
	ocsa_alu ocsa_alu_inst (.CLK, .RST_N, .CMD, .DATA_IN, .ACC_SUM, .ACC_CARRY, .MCAND,
		.MPLIER, .MULT_RUN, .FULL_CARRY_RUN, .MULT_DONE, .CARRY_DONE);
	ocsa_seq_model ocsa_seq_model_inst (.CLK, .MPLIER, .MULT_RUN, .MULT_DONE, .CARRY_DONE,
		.CMD, .DATA_IN);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// The lost top carry re-enters at the bottom
	function automatic int oc_add(input int x, input int y);
		int s;
		s = x + y;
		return s > M ? (s & M) + 1 : s;
	endfunction
	task automatic tally_and_finish();
		mismatches += ocsa_seq_model_inst.timeouts;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(32'hF1B1));
		repeat (16) @(negedge CLK);
		RST_N = 1'b1;
		@(negedge CLK);
		check("reset", 32'(ACC_SUM | ACC_CARRY | MCAND | MPLIER), 32'h0);
		for (int i = 0; i < 8; i++) begin
			a = (i == 0) ? M : $urandom & M;
			b = (i == 0) ? 32'h1 : $urandom & M;
			ocsa_seq_model_inst.issue(8, 16'(b));
			ocsa_seq_model_inst.issue(10, 16'(a));
			ocsa_seq_model_inst.issue(6, '0);
			@(negedge CLK);
			check("add sum", 32'(ACC_SUM), a ^ b);
			check("add carry", 32'(ACC_CARRY), a & b);
			ocsa_seq_model_inst.issue(3, '0);
			@(negedge CLK);
			c = ((a & b) << 1 | (a & b) >> 15) & M;
			check("step sum", 32'(ACC_SUM), a ^ b ^ c);
			check("step carry", 32'(ACC_CARRY), (a ^ b) & c);
			ocsa_seq_model_inst.full_carry();
			check("sum", 32'(ACC_SUM), oc_add(a, b));
			check("carry done", 32'(ocsa_seq_model_inst.carry_seen), 32'h1);
			check("full run", 32'(FULL_CARRY_RUN), 32'h0);
			ocsa_seq_model_inst.issue(10, 16'(a));
			ocsa_seq_model_inst.issue(5, '0);
			ocsa_seq_model_inst.full_carry();
			r = oc_add(a, ~b & M);
			check("difference", 32'(ACC_SUM), r);
			ocsa_seq_model_inst.issue(4, '0);
			@(negedge CLK);
			check("negated", 32'(ACC_SUM), ~r & M);
		end
		$display("add subtract negate test done");
		for (int i = 0; i < 6; i++) begin
			a = (i == 0) ? 32'h7FFF : $urandom & 32'h7FFF;
			b = (i == 0) ? M : (i == 1) ? 32'h0 : $urandom & M;
			ocsa_seq_model_inst.multiply(16'(a), 16'(b));
			r = a * b;
			check("product high", 32'(ACC_SUM), r >> 16);
			check("product low", 32'(MPLIER), r & M);
			check("multiplicand", 32'(MCAND), a);
			check("shifts", 32'(ocsa_seq_model_inst.shifts), OCSA_WIDTH);
			check("mult done", 32'(ocsa_seq_model_inst.mult_done_seen), 32'h1);
			check("mult run", 32'(MULT_RUN), 32'h0);
		end
		$display("multiply test done");
		tally_and_finish();
	end
endmodule
